/* File: logic/kpw_keypress_wake_unit.sv */
// Notes on behaviour
// RQ1: Writing the stop request enters stop unless a release is already present.
// RQ2: In level mode, a low enabled key pin starts release from stop.
// RQ3: Each key pin counts only when its own enable bit is set.
// RQ4: Software checks enabled key pins read high before requesting stop.
// RQ5: Stop request with release already present goes straight to warm-up.
// RQ6: Mode 1: release pin high, keys low; mode 0: release pin rising edge only.
// RQ7: In edge mode software disables keys or keys stay high throughout stop.
// RQ8: The release pin has no enable and always releases stop.
// RQ9: When keys wake the part, the release pin is held low during stop.
// RQ10: A key wake pin is never used as an analog input meanwhile.
// RQ11: Wake detection uses an input path apart from the port read path.
// RQ12: Key enable register: write-only bits 7..4, one per pin, reset 0.
// RQ13: Software sets each key wake pin as input before enabling it.
// RQ14: Wake detection itself is combinational and needs no running clock; here the pins first pass the aclk synchroniser.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
module kpw_keypress_wake_unit
   import kpw_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [KPW_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [KPW_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  wake_key_pin_a,
   input  wire logic                  wake_key_pin_b,
   input  wire logic                  wake_key_pin_c,
   input  wire logic                  wake_key_pin_d,
   input  wire logic                  stop_release_pin,
   output logic                       stop_mode_q,
   output logic                       warmup_start_q
);

   // ----------------------------------------------------------------
   // Pin paths
   // ----------------------------------------------------------------
   logic [KPW_NKEY-1:0] key_raw;
   logic [KPW_NKEY-1:0] port_lvl;
   logic [KPW_NKEY:0]   wake_lvl;
   logic                stop_prev_q;
   logic                key_hit;
   logic                release_req;

   assign key_raw = {wake_key_pin_d, wake_key_pin_c, wake_key_pin_b, wake_key_pin_a};

   // Two separate input paths, so a port read may disagree with the detector
   kpw_sync3 #(.WIDTH(KPW_NKEY)) u_port_sync (        // see RQ11
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (key_raw),
      .level_q  (port_lvl)
   );

   kpw_sync3 #(.WIDTH(KPW_NKEY + 1)) u_wake_sync (    // see RQ11
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({stop_release_pin, key_raw}),
      .level_q  (wake_lvl)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic                relm_q;
   logic [KPW_NKEY-1:0] key_en_q;
   logic                abort_q;
   logic                stop_req;
   kpw_state_t          state_q;
   kpw_state_t          state_d;

   kpw_wake_detect u_detect (
      .relm        (relm_q),
      .key_lvl     (wake_lvl[KPW_NKEY-1:0]),
      .key_en      (key_en_q),
      .stop_lvl    (wake_lvl[KPW_NKEY]),
      .stop_prev   (stop_prev_q),
      .key_hit     (key_hit),
      .stop_hit    (),
      .release_req (release_req)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic                  aw_held_q;
   logic                  w_held_q;
   logic [KPW_ADDR_W-1:0] awaddr_q;
   logic [31:0]           wdata_q;
   logic                  wstrb0_q;
   logic                  wr_go;

   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= KPW_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == KPW_SCR_OFF || awaddr_q == KPW_KEYEN_OFF ||
                             awaddr_q == KPW_STAT_OFF || awaddr_q == KPW_PORT_OFF)
                            ? KPW_RESP_OKAY : KPW_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Stop request is a self-clearing command bit
   assign stop_req = wr_go && wstrb0_q && awaddr_q == KPW_SCR_OFF
                     && wdata_q[KPW_SCR_STOP_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         relm_q   <= KPW_RELM_RST;
         key_en_q <= KPW_KEYEN_RST;                                   // see RQ12
      end
      else if (wr_go && wstrb0_q)
      begin
         if (awaddr_q == KPW_SCR_OFF)
         begin
            relm_q <= wdata_q[KPW_SCR_RELM_BIT];
         end
         if (awaddr_q == KPW_KEYEN_OFF)
         begin
            key_en_q <= wdata_q[KPW_KEYEN_MSB:KPW_KEYEN_LSB];        // see RQ12
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_word;
   logic        rd_ok;

   always_comb
   begin
      rd_word = 32'h0;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         KPW_SCR_OFF:   rd_word[KPW_SCR_RELM_BIT] = relm_q;
         KPW_KEYEN_OFF: rd_word = 32'h0;                              // see RQ12
         KPW_STAT_OFF:
         begin
            rd_word[KPW_STAT_STOP_BIT] = stop_mode_q;
            rd_word[KPW_STAT_ABRT_BIT] = abort_q;
         end
         KPW_PORT_OFF:  rd_word[KPW_NKEY-1:0] = port_lvl;             // see RQ11
         default:       rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= KPW_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? KPW_RESP_OKAY : KPW_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stop and release sequencer
   // ----------------------------------------------------------------
   // A release pin already high refuses entry in either mode, not only its edge
   logic entry_abort;

   assign entry_abort = key_hit | wake_lvl[KPW_NKEY];                 // see RQ5 see RQ8
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         KPW_RUN:
         begin
            if (stop_req)
            begin
               state_d = entry_abort ? KPW_WARM : KPW_STOP;           // see RQ1 see RQ5
            end
         end
         KPW_STOP:
         begin
            if (release_req)
            begin
               state_d = KPW_WARM;                                    // see RQ2 see RQ8
            end
         end
         KPW_WARM: state_d = KPW_RUN;
         default:  state_d = KPW_RUN;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q        <= KPW_RUN;
         stop_mode_q    <= 1'b0;
         warmup_start_q <= 1'b0;
         abort_q        <= 1'b0;
         stop_prev_q    <= 1'b0;
      end
      else
      begin
         state_q        <= state_d;
         stop_mode_q    <= state_d == KPW_STOP;
         warmup_start_q <= state_d == KPW_WARM;
         stop_prev_q    <= wake_lvl[KPW_NKEY];
         if (state_q == KPW_RUN && stop_req)
         begin
            abort_q <= entry_abort;                                   // see RQ5
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic ar_hs;

   assign ar_hs = s_axi_arvalid && s_axi_arready;

   sequence s_warm_then_run;
      state_q == KPW_WARM && warmup_start_q ##1 state_q == KPW_RUN && !warmup_start_q;
   endsequence

   property p_stop_entry;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_RUN && stop_req && !entry_abort |=> state_q == KPW_STOP && stop_mode_q;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop not entered"); // see RQ1
   property p_abort;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_RUN && stop_req && entry_abort |=> s_warm_then_run;
   endproperty
   a_abort: assert property (p_abort) else $error("stop not aborted"); // see RQ5
   property p_key_level;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_STOP && relm_q && |(~wake_lvl[KPW_NKEY-1:0] & key_en_q)
      |=> s_warm_then_run;
   endproperty
   a_key_level: assert property (p_key_level) else $error("key low missed"); // see RQ2
   property p_key_masked;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_STOP && !wake_lvl[KPW_NKEY] && &(wake_lvl[KPW_NKEY-1:0] | ~key_en_q)
      |=> state_q == KPW_STOP;
   endproperty
   a_key_masked: assert property (p_key_masked) else $error("masked key woke"); // see RQ3
   property p_edge_mode;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_STOP && !relm_q && !(wake_lvl[KPW_NKEY] && !$past(wake_lvl[KPW_NKEY]))
      |=> state_q == KPW_STOP;
   endproperty
   a_edge_mode: assert property (p_edge_mode) else $error("edge mode woke"); // see RQ6
   property p_edge_rise;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_STOP && !relm_q && $rose(wake_lvl[KPW_NKEY]) |=> s_warm_then_run;
   endproperty
   a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed"); // see RQ6
   property p_pin_level;
      @(posedge aclk) disable iff (!aresetn)
      state_q == KPW_STOP && relm_q && wake_lvl[KPW_NKEY] |=> ##[0:1] state_q == KPW_RUN;
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("release pin ignored"); // see RQ8
   property p_port_read;
      @(posedge aclk) disable iff (!aresetn)
      ar_hs && s_axi_araddr == KPW_PORT_OFF
      |=> s_axi_rvalid && s_axi_rdata[KPW_NKEY-1:0] == $past(port_lvl);
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read wrong"); // see RQ11
   property p_keyen_wo;
      @(posedge aclk) disable iff (!aresetn)
      ar_hs && s_axi_araddr == KPW_KEYEN_OFF |=> s_axi_rdata == 32'h0;
   endproperty
   a_keyen_wo: assert property (p_keyen_wo) else $error("enable reg readable"); // see RQ12

endmodule : kpw_keypress_wake_unit

/* File: logic/kpw_pkg.sv */
package kpw_pkg;

   // ----------------------------------------------------------------
   // Register map and bus answers
   // ----------------------------------------------------------------
   localparam int unsigned KPW_ADDR_W       = 8;
   localparam int unsigned KPW_NKEY         = 4;
   localparam logic [7:0]  KPW_SCR_OFF      = 8'h00;
   localparam logic [7:0]  KPW_KEYEN_OFF    = 8'h04;
   localparam logic [7:0]  KPW_STAT_OFF     = 8'h08;
   localparam logic [7:0]  KPW_PORT_OFF     = 8'h0c;
   localparam logic [1:0]  KPW_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  KPW_RESP_SLVERR  = 2'h2;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned KPW_SCR_STOP_BIT  = 0;
   localparam int unsigned KPW_SCR_RELM_BIT  = 1;
   localparam int unsigned KPW_KEYEN_LSB     = 4;
   localparam int unsigned KPW_KEYEN_MSB     = 7;
   localparam int unsigned KPW_STAT_STOP_BIT = 0;
   localparam int unsigned KPW_STAT_ABRT_BIT = 1;
   localparam logic        KPW_RELM_RST      = 1'b0;
   localparam logic [3:0]  KPW_KEYEN_RST     = 4'h0;

   // ----------------------------------------------------------------
   // Power states, Gray coded along run, stop, warm-up
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      KPW_RUN  = 2'b00,
      KPW_STOP = 2'b01,
      KPW_WARM = 2'b11
   } kpw_state_t;

endpackage : kpw_pkg

/* File: logic/kpw_sync3.sv */
module kpw_sync3 #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level_q
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // A change is taken only once the second and third stages agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         level_q <= '0;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < int'(WIDTH); i++)
         begin
            if (s2_q[i] == s3_q[i])
            begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

endmodule : kpw_sync3

/* File: logic/kpw_wake_detect.sv */
module kpw_wake_detect
   import kpw_pkg::*;
(
   input  wire logic                relm,
   input  wire logic [KPW_NKEY-1:0] key_lvl,
   input  wire logic [KPW_NKEY-1:0] key_en,
   input  wire logic                stop_lvl,
   input  wire logic                stop_prev,
   output logic                     key_hit,
   output logic                     stop_hit,
   output logic                     release_req
);

   // Combinational, but its inputs come from the aclk synchroniser and the registered stop_prev, so detection needs aclk
   always_comb
   begin
      key_hit     = relm & (|(~key_lvl & key_en));           // see RQ3 see RQ14
      stop_hit    = relm ? stop_lvl : (stop_lvl & ~stop_prev); // see RQ6 see RQ8
      release_req = key_hit | stop_hit;                        // see RQ2
   end

endmodule : kpw_wake_detect

/* File: tb/kpw_key_model.sv */
// ----------------------------------------------------------------
// Keys and release switch on the far side of the wake pins
// ----------------------------------------------------------------
module kpw_key_model
(
   input  wire logic [3:0] press,
   input  wire logic       push,
   output logic      [3:0] key_pin,
   output logic            stop_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pull-ups hold a released key high, so an idle key never looks like a wake
   // Keys only drive digital levels into pins set as inputs; nothing analog
   // shares them here
   assign key_pin  = ~press;
   // The bench keeps the switch low whenever keys are the intended wake source
   assign stop_pin = push;

endmodule : kpw_key_model

/* File: tb/kpw_keypress_wake_unit_bench.sv */
module kpw_keypress_wake_unit_bench;
   import kpw_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, press, key_pin;
   logic [1:0]  bresp, rresp;
   logic        push, stop_pin, stop_mode_q, warmup_start_q;
   int          fail_count, check_count;

   kpw_key_model keys (.press(press), .push(push), .key_pin(key_pin), .stop_pin(stop_pin));

   kpw_keypress_wake_unit dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wake_key_pin_a(key_pin[0]), .wake_key_pin_b(key_pin[1]),
      .wake_key_pin_c(key_pin[2]), .wake_key_pin_d(key_pin[3]),
      .stop_release_pin(stop_pin), .stop_mode_q(stop_mode_q),
      .warmup_start_q(warmup_start_q)
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Reporting and comparison
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic miss(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : miss

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp)
         miss(m);
   endtask : chk_data

   task automatic chk_bit(input logic got, input logic exp, input string m);
      check_count++;
      if (got !== exp)
         miss(m);
   endtask : chk_bit

   // Release already present at the stop request turns it into warm-up
   function automatic logic exp_abort(input logic relm, input logic [3:0] en,
                                      input logic [3:0] pr, input logic sp);
      return sp | (relm & |(en & pr));
   endfunction : exp_abort

   // ----------------------------------------------------------------
   // Bus cycles; bready and rready stay high for the whole run
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            return;
         end
      end
      miss("write timeout");
      test_done();
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            return;
         end
      end
      miss("read timeout");
      test_done();
   endtask : axi_rd

   // Pins pass a synchroniser, so ten edges cover any detection delay
   task automatic expect_release(input logic exp);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 10 && seen !== 1'b1; n++)
      begin
         @(posedge aclk);
         seen = warmup_start_q;
      end
      chk_bit(seen, exp, "release");
      if (exp)
      begin
         @(posedge aclk);
         chk_bit(warmup_start_q, 1'b0, "pulse width");
         chk_bit(stop_mode_q, 1'b0, "stop left");
      end
      else
         chk_bit(stop_mode_q, 1'b1, "stop held");
   endtask : expect_release

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic        relm, sp, ab;
      logic [3:0]  en, pr, one;
      logic [31:0] d;
      logic [1:0]  r;
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, arvalid, press, push} = '0;
      bready = 1'b1;
      rready = 1'b1;
      void'($urandom(32'hb0d9));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(KPW_SCR_OFF, d, r);
      chk_data(d, 32'h0, "control reset");
      axi_wr(KPW_KEYEN_OFF, 32'hf0, r);
      axi_rd(KPW_KEYEN_OFF, d, r);
      chk_data(d, 32'h0, "enable reads zero");
      axi_wr(8'h10, 32'h3, r);
      chk_data({30'h0, r}, {30'h0, KPW_RESP_SLVERR}, "unmapped write");
      axi_rd(8'h10, d, r);
      chk_data({d[29:0], r}, {30'h0, KPW_RESP_SLVERR}, "unmapped read");
      axi_wr(KPW_KEYEN_OFF, 32'h00, r);
      for (int i = 0; i < 14; i++)
      begin
         relm = (i == 0) ? 1'b1 : 1'($urandom_range(1, 0));
         en   = (i == 0) ? 4'h0 : 4'($urandom());
         pr   = (i == 0) ? 4'hf : 4'($urandom());
         if (!relm)
            pr = pr & ~en;
         sp = (i != 0) && ($urandom_range(3, 0) == 0);
         ab = exp_abort(relm, en, pr, sp);
         axi_wr(KPW_KEYEN_OFF, {24'h0, en, 4'h0}, r);
         axi_wr(KPW_SCR_OFF, {30'h0, relm, 1'b0}, r);
         press <= pr;
         push  <= sp;
         repeat (8) @(posedge aclk);
         axi_rd(KPW_PORT_OFF, d, r);
         chk_data(d, {28'h0, ~pr}, "port levels");
         axi_wr(KPW_SCR_OFF, {30'h0, relm, 1'b1}, r);
         // Entry state launches with the response, so it stands at this edge
         chk_bit(warmup_start_q, ab, "warm-up at entry");
         chk_bit(stop_mode_q, !ab, "stop entry");
         chk_data({30'h0, r}, {30'h0, KPW_RESP_OKAY}, "stop write response");
         @(posedge aclk);
         chk_bit(warmup_start_q, 1'b0, "entry pulse width");
         axi_rd(KPW_STAT_OFF, d, r);
         chk_data(d, {30'h0, ab, !ab}, "status");
         if (!ab)
         begin
            press <= pr | ~en;
            expect_release(1'b0);
            one = 4'h0;
            while (relm && en != 4'h0 && one == 4'h0)
               one = en & (4'h1 << $urandom_range(3, 0));
            if (one != 4'h0 && $urandom_range(1, 0) == 0)
               press <= pr | ~en | one;
            else
               push <= 1'b1;
            expect_release(1'b1);
         end
         press <= 4'h0;
         push  <= 1'b0;
         repeat (8) @(posedge aclk);
      end
      test_done();
   end

endmodule : kpw_keypress_wake_unit_bench
